// ===== pkg/meter_ctrl_pkg.sv
/*
 * Shared constants for the reading, ranging and math control block:
 * register offsets, control field positions, reset values and enums.
 * Assumes a single 50 MHz system clock and a 32-bit APB register bus.
 */
`default_nettype none
package meter_ctrl_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RANGE = 8'h04;
	localparam logic [7:0] OFS_RES = 8'h08;
	localparam logic [7:0] OFS_REFR = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RESULT = 8'h14;
	localparam logic [7:0] OFS_NULLV = 8'h18;
	localparam logic [7:0] OFS_MIN = 8'h1C;
	localparam logic [7:0] OFS_MAX = 8'h20;
	localparam logic [7:0] OFS_AVG = 8'h24;
	localparam logic [7:0] OFS_COUNT = 8'h28;
	localparam logic [7:0] OFS_DBREL = 8'h2C;
	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int CTRL_FN_LSB = 0;
	localparam int CTRL_TRIG_LSB = 4;
	localparam int CTRL_NULL = 8;
	localparam int CTRL_MINMAX = 9;
	localparam int CTRL_DB = 10;
	localparam int CTRL_DBM = 11;
	localparam int CTRL_RATIO = 12;
	localparam int RANGE_AUTO = 8;
	// ----------------------------------------------------------------
	// Ranging thresholds, in counts of the present full scale
	// ----------------------------------------------------------------
	localparam logic [31:0] FULL_SCALE = 32'h000186A0;
	localparam logic [31:0] DOWN_LEVEL = FULL_SCALE / 32'h0000000A;
	localparam logic [31:0] UP_LEVEL = (FULL_SCALE / 32'h0000000A) * 32'h0000000C;
	localparam logic [2:0] RANGE_1K = 3'h1;
	localparam logic [2:0] RANGE_1V = 3'h1;
	localparam logic [2:0] RANGE_RESET = 3'h0;
	// ----------------------------------------------------------------
	// dBm arithmetic in centi-dB
	// ----------------------------------------------------------------
	localparam logic [4:0] REFR_DEFAULT = 5'h0B;
	localparam logic [4:0] REFR_LAST = 5'h10;
	localparam logic signed [31:0] MW_OFFSET_CDB = 32'sh00000BB8;
	localparam logic signed [31:0] MICRO_CDB = 32'sh00002EE0;
	localparam logic [9:0] L20_STEP = 10'h25A;
	localparam int DIV_STEPS = 48;
	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {FN_DCV, FN_ACV, FN_DCI, FN_ACI, FN_OHM2, FN_OHM4,
		FN_FREQ, FN_PER, FN_CONT, FN_DIODE} function_type;
	typedef enum logic [1:0] {TRIG_AUTO, TRIG_SINGLE, TRIG_EXT} trig_type;
	typedef enum logic [1:0] {RES_4, RES_5, RES_6} res_type;
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_RATIO, ST_MATH, ST_AVG} state_type;
	localparam int NUM_FN = 10;
endpackage
`default_nettype wire

// ===== rtl/reading_range_and_math_control.sv
/*
 * Reading, ranging and math control for a bench multimeter: trigger
 * sequencing, per-function range and resolution memory, overload,
 * ratio, null, min/max/average/count, dB relative and dBm.
 * Assumes the analog front end reports each reading in microvolt-like
 * units plus a level relative to full scale, and that the power
 * reference setting is held by outside non-volatile storage.
 */
`timescale 1ns/10ps
`default_nettype none

module reading_range_and_math_control
	import meter_ctrl_pkg::*;
#(
	parameter int NUM_RANGES = 7
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic remote_reset_i,
	input wire logic remote_i,
	input wire logic single_key_i,
	input wire logic ext_trig_i,
	input wire logic meas_busy_i,
	input wire logic reading_valid_i,
	input wire logic signed [31:0] reading_i,
	input wire logic signed [31:0] ref_reading_i,
	input wire logic [31:0] level_i,
	input wire logic [31:0] amplitude_i,
	input wire logic fe_overload_i,
	input wire logic [4:0] nv_ref_index_i,
	output logic nv_write_o,
	output logic [4:0] nv_ref_index_o,
	output logic meas_start_o,
	output logic [3:0] function_o,
	output logic [2:0] range_o,
	output logic [1:0] resolution_o,
	output logic ref_autorange_o,
	output logic overload_indication_o,
	output logic signed [31:0] result_o,
	output logic result_valid_o
);
	// Range index is three bits wide and the fixed functions need two ranges
	if (NUM_RANGES < 2 || NUM_RANGES > 8) begin : g_bad_ranges
		$error("NUM_RANGES must be 2 to 8");
	end

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Magnitude of a signed reading
	function automatic logic [31:0] mag(input logic signed [31:0] v);
		mag = v[31] ? 32'(-v) : 32'(v);
	endfunction

	// 20*log10(x) in centi-dB from the leading one and 8 mantissa bits
	function automatic logic signed [31:0] l20(input logic [31:0] x);
		logic [4:0] p;
		logic [7:0] f;
		logic [31:0] s;
		p = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (x[i]) p = 5'(i);
		end
		s = x << (5'h1F - p);
		f = s[30:23];
		l20 = 32'(p) * 32'(L20_STEP) + 32'((18'(f) * 18'(L20_STEP)) >> 8);
	endfunction

	// 10*log10(reference ohms) in centi-dB for each list entry
	function automatic logic signed [31:0] ten_log_r(input logic [4:0] i);
		unique case (i)
			5'h00: ten_log_r = 32'sd1699;
			5'h01: ten_log_r = 32'sd1875;
			5'h02: ten_log_r = 32'sd1968;
			5'h03: ten_log_r = 32'sd2041;
			5'h04: ten_log_r = 32'sd2093;
			5'h05: ten_log_r = 32'sd2097;
			5'h06: ten_log_r = 32'sd2130;
			5'h07: ten_log_r = 32'sd2176;
			5'h08: ten_log_r = 32'sd2398;
			5'h09: ten_log_r = 32'sd2477;
			5'h0A: ten_log_r = 32'sd2699;
			5'h0B: ten_log_r = 32'sd2778;
			5'h0C: ten_log_r = 32'sd2903;
			5'h0D: ten_log_r = 32'sd2954;
			5'h0E: ten_log_r = 32'sd3000;
			5'h0F: ten_log_r = 32'sd3079;
			default: ten_log_r = 32'sd3903;
		endcase
	endfunction

	// Functions with a fixed range and resolution
	function automatic logic fixed_fn(input logic [3:0] f);
		fixed_fn = (f == FN_CONT) || (f == FN_DIODE);
	endfunction

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	function_type fn;
	trig_type trig_mode;
	state_type state;
	logic null_en, minmax_en, db_en, dbm_en, ratio_en;
	logic null_armed, rel_armed;
	logic [2:0] range_mem [NUM_FN];
	logic auto_mem [NUM_FN];
	logic [1:0] res_mem [NUM_FN];
	logic [4:0] ref_index;
	logic nv_loaded;
	logic signed [31:0] null_value, rel_value, min_value, max_value, avg_value;
	logic signed [47:0] sum_value, next_sum;
	logic [31:0] next_count;
	logic [31:0] count_value;
	logic signed [31:0] raw_value, ref_value, ratio_value;
	logic [31:0] level_value;
	logic overload;
	logic trig_pending, ext_trig_d;
	logic [47:0] div_quo;
	logic [32:0] div_rem;
	logic [31:0] div_den;
	logic [5:0] div_cnt;
	logic div_neg;
	logic [32:0] div_try;
	logic signed [31:0] work, dbm_value, next_result;

	wire logic wr = psel_i && penable_i && pwrite_i;
	wire logic fn_write = wr && paddr_i == OFS_CTRL;
	wire logic [3:0] new_fn = pwdata_i[CTRL_FN_LSB +: 4];
	wire logic fn_change = fn_write && new_fn != fn && new_fn < 4'(NUM_FN);
	wire logic [2:0] top_range = (fn == FN_DIODE || fn == FN_CONT) ? 3'(NUM_RANGES - 2)
		: 3'(NUM_RANGES - 1);
	wire logic [2:0] cur_range = range_mem[fn];
	wire logic ext_fall = ext_trig_d && !ext_trig_i;

	// ----------------------------------------------------------------
	// Control register and math mode enables
	// ----------------------------------------------------------------
	// Null, min/max and dB relative bits are dropped on function change so stale values never apply
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || remote_reset_i) begin
			fn <= FN_DCV;
			trig_mode <= TRIG_AUTO;
			null_en <= 1'b0;
			minmax_en <= 1'b0;
			db_en <= 1'b0;
			dbm_en <= 1'b0;
			ratio_en <= 1'b0;
		end else if (fn_write) begin
			if (new_fn < 4'(NUM_FN)) fn <= function_type'(new_fn);
			if (pwdata_i[CTRL_TRIG_LSB +: 2] != 2'h3)
				trig_mode <= trig_type'(pwdata_i[CTRL_TRIG_LSB +: 2]);
			ratio_en <= pwdata_i[CTRL_RATIO] && new_fn == FN_DCV;
			null_en <= pwdata_i[CTRL_NULL] && !pwdata_i[CTRL_RATIO]
				&& !fixed_fn(new_fn) && !fn_change;
			minmax_en <= pwdata_i[CTRL_MINMAX] && !fixed_fn(new_fn) && !fn_change;
			db_en <= pwdata_i[CTRL_DB] && !fn_change && (new_fn == FN_DCV || new_fn == FN_ACV);
			dbm_en <= pwdata_i[CTRL_DBM] && (new_fn == FN_DCV || new_fn == FN_ACV);
		end
	end

	// ----------------------------------------------------------------
	// Per-function range, ranging method and resolution memory
	// ----------------------------------------------------------------
	// Autorange steps only after a completed reading, one range at a time
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || remote_reset_i) begin
			for (int i = 0; i < NUM_FN; i++) begin
				auto_mem[i] <= 1'b1;
				range_mem[i] <= RANGE_RESET;
				res_mem[i] <= RES_5;
			end
		end else begin
			if (wr && paddr_i == OFS_RANGE && !fixed_fn(fn)) begin
				auto_mem[fn] <= pwdata_i[RANGE_AUTO];
				if (pwdata_i[2:0] <= top_range) range_mem[fn] <= pwdata_i[2:0];
			end else if (state == ST_MATH && auto_mem[fn] && !fixed_fn(fn)) begin
				if (level_value > UP_LEVEL && cur_range < top_range)
					range_mem[fn] <= cur_range + 3'h1;
				else if (level_value < DOWN_LEVEL && cur_range != 3'h0)
					range_mem[fn] <= cur_range - 3'h1;
			end
			if (wr && paddr_i == OFS_RES && !fixed_fn(fn) && pwdata_i[1:0] != 2'h3)
				res_mem[fn] <= pwdata_i[1:0];
		end
	end

	// Fixed functions override the remembered settings
	always_comb begin
		function_o = fn;
		range_o = (fn == FN_CONT) ? RANGE_1K : (fn == FN_DIODE) ? RANGE_1V : cur_range;
		resolution_o = fixed_fn(fn) ? RES_5 : res_mem[fn];
		ref_autorange_o = ratio_en;
	end

	// ----------------------------------------------------------------
	// Reference resistance, loaded from non-volatile storage
	// ----------------------------------------------------------------
	// Remote reset leaves it alone; the store is reloaded after power-on
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			nv_loaded <= 1'b0;
			ref_index <= REFR_DEFAULT;
			nv_write_o <= 1'b0;
			nv_ref_index_o <= REFR_DEFAULT;
		end else begin
			nv_write_o <= 1'b0;
			if (!nv_loaded) begin
				nv_loaded <= 1'b1;
				ref_index <= (nv_ref_index_i <= REFR_LAST) ? nv_ref_index_i : REFR_DEFAULT;
			end else if (wr && paddr_i == OFS_REFR && pwdata_i[4:0] <= REFR_LAST) begin
				ref_index <= pwdata_i[4:0];
				nv_ref_index_o <= pwdata_i[4:0];
				nv_write_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Trigger source
	// ----------------------------------------------------------------
	// A pending trigger survives until the sequencer is free to start
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || remote_reset_i) begin
			ext_trig_d <= 1'b1;
			trig_pending <= 1'b0;
		end else begin
			ext_trig_d <= ext_trig_i;
			if ((trig_mode == TRIG_SINGLE && single_key_i && !remote_i)
				|| (trig_mode == TRIG_EXT && ext_fall))
				trig_pending <= 1'b1;
			else if (state == ST_IDLE && !meas_busy_i)
				trig_pending <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Measurement sequencer with shared serial divider
	// ----------------------------------------------------------------
	assign div_try = {div_rem[31:0], div_quo[47]};

	// Ratio and average share one divider to keep the area small
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || remote_reset_i) begin
			state <= ST_IDLE;
			meas_start_o <= 1'b0;
			raw_value <= 32'h00000000;
			ref_value <= 32'h00000000;
			level_value <= 32'h00000000;
			ratio_value <= 32'h00000000;
			div_quo <= 48'h000000000000;
			div_rem <= 33'h000000000;
			div_den <= 32'h00000000;
			div_cnt <= 6'h00;
			div_neg <= 1'b0;
		end else begin
			meas_start_o <= 1'b0;
			unique case (state)
				ST_IDLE: if (!meas_busy_i && (trig_mode == TRIG_AUTO || trig_pending)) begin
					meas_start_o <= 1'b1;
					state <= ST_WAIT;
				end
				ST_WAIT: if (reading_valid_i) begin
					raw_value <= reading_i;
					ref_value <= ref_reading_i;
					level_value <= (fn == FN_FREQ || fn == FN_PER) ? amplitude_i : level_i;
					if (ratio_en && ref_reading_i != 32'sh0) begin
						div_quo <= {mag(reading_i), 16'h0000};
						div_den <= mag(ref_reading_i);
						div_neg <= reading_i[31] ^ ref_reading_i[31];
						div_rem <= 33'h000000000;
						div_cnt <= 6'(DIV_STEPS);
						state <= ST_RATIO;
					end else begin
						ratio_value <= 32'h00000000;
						state <= ST_MATH;
					end
				end
				ST_RATIO, ST_AVG: if (div_cnt != 6'h00) begin
					div_cnt <= div_cnt - 6'h01;
					if (div_try >= {1'b0, div_den}) begin
						div_rem <= div_try - {1'b0, div_den};
						div_quo <= {div_quo[46:0], 1'b1};
					end else begin
						div_rem <= div_try;
						div_quo <= {div_quo[46:0], 1'b0};
					end
				end else if (state == ST_RATIO) begin
					ratio_value <= div_neg ? -32'(div_quo) : 32'(div_quo);
					state <= ST_MATH;
				end else begin
					state <= ST_IDLE;
				end
				ST_MATH: if (minmax_en) begin
					div_quo <= next_sum[47] ? 48'(-next_sum) : 48'(next_sum);
					div_den <= next_count;
					div_neg <= next_sum[47];
					div_rem <= 33'h000000000;
					div_cnt <= 6'(DIV_STEPS);
					state <= ST_AVG;
				end else begin
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Math chain: ratio, null, dBm and dB relative
	// ----------------------------------------------------------------
	// Overload also covers a level above UP_LEVEL in manual range or on the top range
	always_comb begin
		work = (ratio_en && ref_value != 32'sh0) ? ratio_value : raw_value;
		dbm_value = l20(mag(work)) - MICRO_CDB + MW_OFFSET_CDB - ten_log_r(ref_index);
		overload = fe_overload_i
			|| (level_value > UP_LEVEL && (!auto_mem[fn] || cur_range == top_range));
		if (null_en && !null_armed) next_result = work - null_value;
		else if (db_en && !rel_armed) next_result = dbm_value - rel_value;
		else if (dbm_en || db_en) next_result = dbm_value;
		else next_result = work;
		// Average includes the reading being added in this same cycle
		next_sum = overload ? sum_value : sum_value + 48'(next_result);
		next_count = overload ? count_value : count_value + 32'h00000001;
	end

	// Armed flags mark that the next reading is captured, not subtracted
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || remote_reset_i) begin
			null_value <= 32'h00000000;
			rel_value <= 32'h00000000;
			null_armed <= 1'b0;
			rel_armed <= 1'b0;
			result_o <= 32'h00000000;
			result_valid_o <= 1'b0;
			overload_indication_o <= 1'b0;
		end else begin
			result_valid_o <= 1'b0;
			if (fn_write && (fn_change || !pwdata_i[CTRL_NULL])) begin
				null_value <= 32'h00000000;
				null_armed <= 1'b0;
			end else if (fn_write && pwdata_i[CTRL_NULL] && !null_en) begin
				null_armed <= 1'b1;
			end else if (state == ST_MATH && null_armed && !overload) begin
				null_value <= work;
				null_armed <= 1'b0;
			end
			if (fn_write && (fn_change || !pwdata_i[CTRL_DB])) begin
				rel_value <= 32'h00000000;
				rel_armed <= 1'b0;
			end else if (fn_write && pwdata_i[CTRL_DB] && !db_en) begin
				rel_armed <= 1'b1;
			end else if (state == ST_MATH && rel_armed && !overload) begin
				rel_value <= dbm_value;
				rel_armed <= 1'b0;
			end
			if (state == ST_MATH) begin
				overload_indication_o <= overload;
				result_o <= overload ? 32'h00000000 : next_result;
				result_valid_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Min, max, count and running sum
	// ----------------------------------------------------------------
	// Overloaded readings are left out so they cannot poison the statistics
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || remote_reset_i || (fn_write && (fn_change || !pwdata_i[CTRL_MINMAX]))) begin
			min_value <= 32'h00000000;
			max_value <= 32'h00000000;
			sum_value <= 48'h000000000000;
			count_value <= 32'h00000000;
			avg_value <= 32'h00000000;
		end else if (state == ST_MATH && minmax_en && !overload) begin
			if (count_value == 32'h00000000 || next_result < min_value) min_value <= next_result;
			if (count_value == 32'h00000000 || next_result > max_value) max_value <= next_result;
			sum_value <= sum_value + 48'(next_result);
			count_value <= count_value + 32'h00000001;
		end else if (state == ST_AVG && div_cnt == 6'h00 && div_den != 32'h00000000) begin
			avg_value <= div_neg ? -32'(div_quo) : 32'(div_quo);
		end
	end

	// ----------------------------------------------------------------
	// APB slave: no wait states, read data captured in the setup cycle
	// ----------------------------------------------------------------
	assign pready_o = penable_i;

	// Unmapped addresses answer with an error and read as zero
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			prdata_o <= 32'h00000000;
			pslverr_o <= 1'b0;
		end else if (psel_i && !penable_i) begin
			pslverr_o <= 1'b0;
			unique case (paddr_i)
				OFS_CTRL: prdata_o <= {19'h00000, ratio_en, dbm_en, db_en, minmax_en, null_en,
					2'h0, trig_mode, fn};
				OFS_RANGE: prdata_o <= {23'h000000, auto_mem[fn], 5'h00, range_o};
				OFS_RES: prdata_o <= {30'h00000000, resolution_o};
				OFS_REFR: prdata_o <= {27'h0000000, ref_index};
				OFS_STATUS: prdata_o <= {25'h0000000, trig_pending, overload_indication_o,
					null_armed, rel_armed, state};
				OFS_RESULT: prdata_o <= result_o;
				OFS_NULLV: prdata_o <= null_value;
				OFS_MIN: prdata_o <= min_value;
				OFS_MAX: prdata_o <= max_value;
				OFS_AVG: prdata_o <= avg_value;
				OFS_COUNT: prdata_o <= count_value;
				OFS_DBREL: prdata_o <= rel_value;
				default: begin
					prdata_o <= 32'h00000000;
					pslverr_o <= 1'b1;
				end
			endcase
		end
	end
endmodule // reading_range_and_math_control
`default_nettype wire

// ===== tb/fe_model.sv
/* Front-end model: answers each start with one reading.
   Assumes the bench sets value, level, overload and latency. */
`timescale 1ns/10ps
`default_nettype none
module fe_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [2:0] lat_i,
	input wire logic signed [31:0] val_i,
	input wire logic [31:0] lvl_i,
	input wire logic ovl_i,
	output var logic busy_o = 1'b0,
	output var logic valid_o = 1'b0,
	output var logic signed [31:0] rd_o = 32'sh0,
	output var logic [31:0] lvl_o = 32'h0,
	output var logic ovl_o = 1'b0
);
	logic [2:0] wait_count = 3'h0;
	// Conversion with a latency; while idle the stale reading and level are scrambled, not held
	always @(posedge clk_i) begin
		valid_o <= 1'b0;
		if (start_i) begin
			busy_o <= 1'b1;
			wait_count <= lat_i;
		end else if (busy_o && wait_count == 3'h0) begin
			busy_o <= 1'b0;
			valid_o <= 1'b1;
			rd_o <= val_i;
			lvl_o <= lvl_i;
			ovl_o <= ovl_i;
		end else if (busy_o) begin
			wait_count <= wait_count - 3'h1;
		end else begin
			rd_o <= ~rd_o;
			lvl_o <= ~lvl_o;
		end
	end
endmodule // fe_model
`default_nettype wire

// ===== tb/reading_range_and_math_control_chk.sv
/* Port checker for the reading and math control block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module rrmc_chk
	import meter_ctrl_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic remote_reset_i,
	input wire logic meas_busy_i,
	input wire logic reading_valid_i,
	input wire logic fe_overload_i,
	input wire logic meas_start_o,
	input wire logic [3:0] function_o,
	input wire logic [2:0] range_o,
	input wire logic [1:0] resolution_o,
	input wire logic [4:0] nv_ref_index_o,
	input wire logic overload_indication_o,
	input wire logic result_valid_o
);
	// ----
	// Relations
	// ----
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	sequence s_access; psel_i && penable_i; endsequence
	sequence s_answer; ##[2:51] result_valid_o; endsequence
	a_access_ready: assert property (s_access |-> pready_o)
		else $error("access phase without ready");
	a_start_single: assert property (meas_start_o |=> !meas_start_o)
		else $error("start pulse too long");
	a_start_idle: assert property (meas_start_o |-> !$past(meas_busy_i))
		else $error("start while front end busy");
	a_result_timely: assert property (reading_valid_i |-> s_answer)
		else $error("no result after reading");
	a_overload_shown: assert property (reading_valid_i && fe_overload_i |-> ##[2:53] overload_indication_o)
		else $error("overload not shown");
	a_cont_fixed: assert property (function_o == FN_CONT |-> range_o == RANGE_1K && resolution_o == 2'h1)
		else $error("continuity range or digits wrong");
	a_diode_fixed: assert property (function_o == FN_DIODE |-> range_o == RANGE_1V && resolution_o == 2'h1)
		else $error("diode range or digits wrong");
	a_remote_defaults: assert property (remote_reset_i |=> range_o == RANGE_RESET && resolution_o == 2'h1)
		else $error("remote reset defaults wrong");
	a_nv_kept: assert property (remote_reset_i |=> $stable(nv_ref_index_o))
		else $error("reference index lost");
endmodule // rrmc_chk
bind reading_range_and_math_control rrmc_chk chk (.sys_clk_i, .reset_i, .psel_i, .penable_i,
	.pready_o, .remote_reset_i, .meas_busy_i, .reading_valid_i, .fe_overload_i, .meas_start_o,
	.function_o, .range_o, .resolution_o, .nv_ref_index_o, .overload_indication_o, .result_valid_o);
`default_nettype wire

// ===== tb/tb.sv
/* Self-checking bench for the reading and math control block.
   Assumes the front-end model and the bound checker alongside. */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import meter_ctrl_pkg::*;
	localparam int NR = 7;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, rrst = 0, rem = 0, key = 0, ext = 1, ovl = 0;
	logic [7:0] pa = 0;
	logic [31:0] pwd = 0, prd, lvl = 0, rd, flv;
	logic signed [31:0] val = 0, res, frd, got;
	logic [2:0] lat = 0, rng, r;
	logic busy, vld, fov, pr, perr, err, ms, rv, ov, ra;
	logic [1:0] rsl;
	integer seed = 32'hCCAE, bad_count = 0, compares = 0, starts = 0, s0, v, mn, mx, sm;
	logic [31:0] lv [3] = '{32'h1388, 32'hC350, 32'h1FBD0};
	reading_range_and_math_control #(.NUM_RANGES(NR)) uut (.sys_clk_i(clk), .reset_i(rst),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
		.prdata_o(prd), .pready_o(pr), .pslverr_o(perr), .remote_reset_i(rrst), .remote_i(rem),
		.single_key_i(key), .ext_trig_i(ext), .meas_busy_i(busy), .reading_valid_i(vld),
		.reading_i(frd), .ref_reading_i(32'sh000F4240), .level_i(flv), .amplitude_i(flv),
		.fe_overload_i(fov), .nv_ref_index_i(5'h0B), .nv_write_o(), .nv_ref_index_o(),
		.meas_start_o(ms), .function_o(), .range_o(rng), .resolution_o(rsl),
		.ref_autorange_o(ra), .overload_indication_o(ov), .result_o(res), .result_valid_o(rv));
	fe_model fe (.clk_i(clk), .start_i(ms), .lat_i(lat), .val_i(val), .lvl_i(lvl),
		.ovl_i(ovl), .busy_o(busy), .valid_o(vld), .rd_o(frd), .lvl_o(flv), .ovl_o(fov));
	// Clock, start counter and watchdog
	initial forever #10 clk = ~clk;
	always @(posedge clk) if (ms === 1'b1) starts <= starts + 1;
	initial begin
		#800000;
		bad_count++;
		complete_run;
	end
	// ----
	// Helpers
	// ----
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (pr !== 1'b1);
		rd = prd;
		err = perr;
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask
	task automatic await;
		do @(posedge clk); while (rv !== 1'b1);
		got = res;
		@(posedge clk);
	endtask
	// One key press; latency drawn at random
	task automatic meas(input logic signed [31:0] x, input logic [31:0] l);
		val <= x;
		lvl <= l;
		lat <= 3'($random(seed));
		key <= 1;
		@(posedge clk);
		key <= 0;
		await;
	endtask
	function automatic logic [2:0] step(input logic [2:0] q, input logic [31:0] l);
		if (l < FULL_SCALE / 10 && q != 0) return q - 3'h1;
		if (l > FULL_SCALE / 10 * 12 && q < NR - 1) return q + 3'h1;
		return q;
	endfunction
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		chk("res", 32'(rsl), 32'h1);
		chk("range", 32'(rng), 32'h0);
		apb(0, OFS_REFR, 0);
		chk("refr", rd, 32'h0B);
		apb(1, OFS_REFR, 32'h11);
		apb(0, OFS_REFR, 0);
		chk("refr", rd, 32'h0B);
		apb(1, OFS_REFR, 32'h0);
		apb(1, OFS_CTRL, 32'h8);
		chk("cont", {rng, rsl}, {3'h1, 2'h1});
		apb(1, OFS_CTRL, 32'h10);
		apb(1, OFS_RANGE, 32'h3);
		apb(1, OFS_RES, 32'h2);
		apb(1, OFS_CTRL, 32'h11);
		chk("acv", {rng, rsl}, {3'h0, 2'h1});
		apb(1, OFS_CTRL, 32'h10);
		chk("dcv", {rng, rsl}, {3'h3, 2'h2});
		apb(1, OFS_RANGE, 32'h103);
		r = 3'h3;
		repeat (8) begin
			s0 = starts;
			meas(32'sh64, lv[$unsigned($random(seed)) % 3]);
			r = step(r, lvl);
			chk("auto", 32'(rng), 32'(r));
			chk("starts", starts - s0, 1);
		end
		ovl <= 1;
		meas(32'sh64, 32'hC350);
		chk("overload_indication", 32'(ov), 1);
		ovl <= 0;
		apb(1, OFS_CTRL, 32'h110);
		meas(32'sh1F4, 32'hC350);
		meas(32'sh320, 32'hC350);
		chk("null", got, 32'h12C);
		apb(0, OFS_NULLV, 0);
		chk("nullv", rd, 32'h1F4);
		apb(1, OFS_CTRL, 32'h10);
		apb(0, OFS_NULLV, 0);
		chk("nullv", rd, 0);
		apb(1, OFS_CTRL, 32'h210);
		mn = 32'h7FFFFFFF;
		mx = 32'h80000000;
		sm = 0;
		repeat (4) begin
			v = $random(seed) % 1000;
			meas(v, 32'hC350);
			if (v < mn) mn = v;
			if (v > mx) mx = v;
			sm += v;
		end
		repeat (50) @(posedge clk);
		apb(0, OFS_MIN, 0);
		chk("min", rd, mn);
		apb(0, OFS_MAX, 0);
		chk("max", rd, mx);
		apb(0, OFS_AVG, 0);
		chk("avg", rd, sm / 4);
		apb(0, OFS_COUNT, 0);
		chk("count", rd, 4);
		apb(1, OFS_CTRL, 32'h10);
		apb(0, OFS_COUNT, 0);
		chk("count", rd, 0);
		apb(1, OFS_CTRL, 32'h410);
		meas(32'sh7A120, 32'hC350);
		meas(32'sh7A120, 32'hC350);
		chk("db", got, 0);
		apb(1, OFS_CTRL, 32'h10);
		apb(0, OFS_DBREL, 0);
		chk("dbrel", rd, 0);
		// 1 V into 50 ohm is 13.01 dBm; half a dB of log error allowed
		apb(1, OFS_CTRL, 32'h810);
		meas(32'sh000F4240, 32'hC350);
		chk("dbm", 32'(got > 1251 && got < 1351), 1);
		apb(1, OFS_CTRL, 32'h1010);
		meas(32'sh001E8480, 32'hC350);
		chk("ratio", got, 32'h20000);
		chk("refauto", 32'(ra), 1);
		apb(1, OFS_CTRL, 32'h20);
		s0 = starts;
		ext <= 0;
		await;
		ext <= 1;
		chk("ext", starts - s0, 1);
		apb(1, OFS_CTRL, 32'h10);
		// Key under remote control, then remote reset and unmapped access
		rem <= 1;
		s0 = starts;
		key <= 1;
		@(posedge clk);
		key <= 0;
		repeat (30) @(posedge clk);
		chk("remote", starts - s0, 0);
		rrst <= 1;
		@(posedge clk);
		rrst <= 0;
		repeat (2) @(posedge clk);
		chk("rres", {rng, rsl}, {3'h0, 2'h1});
		apb(0, OFS_REFR, 0);
		chk("refr", rd, 0);
		apb(0, 8'h40, 0);
		chk("slverr", 32'(err), 1);
		complete_run;
	end
endmodule // tb
`default_nettype wire
